/* inc/local_if_defines.svh */
`ifndef LOCAL_IF_DEFINES_SVH
`define LOCAL_IF_DEFINES_SVH
// ******************************************************************
// timing
// ******************************************************************
`define HCLK_PERIOD_NS   10
`define MAIN_CLOCK_MHZ   40
`define RST_PULSE_NS     100
// ******************************************************************
// bridge registers (ahb byte offsets)
// ******************************************************************
`define BR_LADDR   5'h00
`define BR_CTRL    5'h04
`define BR_WR16    5'h08
`define BR_WR32    5'h0C
`define BR_RD16    5'h10
`define BR_RD32    5'h14
`define BR_RESET   5'h18
`define BR_STATUS  5'h1C
`define BR_ACCESS_BIT 0
`define BR_HALF_STEP  16'h0002
// ******************************************************************
// user registers (local 16-bit addresses)
// ******************************************************************
`define UR_SCRATCH   16'h0000
`define UR_A_LO      16'h0002
`define UR_A_HI      16'h0004
`define UR_B_LO      16'h0006
`define UR_B_HI      16'h0008
`define UR_C_LO      16'h000A
`define UR_C_HI      16'h000C
`define UR_COAX      16'h000E
`define UR_EXP_CTRL  16'h0012
`define UR_EXP_IDENT 16'h0014
`define UR_DCFG      16'h0016
`define UR_DSTAT     16'h0018
`define UR_DDRIVE    16'h001A
`define UR_SPARE     16'h001C
`define UR_LED       16'h001E
`define UR_EXP_OUT   16'h0020
`define UR_EXP_IN    16'h0040
`define UR_EXP_SPAN  16'h000C
`define SCRATCH_RST  16'hA5C3
`define DCFG_WE_BIT  10
`define PIN_W        195
`endif

/* inc/local_if_pkg.sv */
`default_nettype none
`include "local_if_defines.svh"
package local_if_pkg;
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_SET_LO = 8'h02,
    ST_RD_LO  = 8'h04,
    ST_SET_HI = 8'h08,
    ST_RD_HI  = 8'h10,
    ST_WR_LO  = 8'h20,
    ST_WR_HI  = 8'h40,
    ST_DONE   = 8'h80
  } bridge_state_t;

  typedef struct packed {
    bridge_state_t        st;
    logic                 ph_valid;
    logic                 ph_write;
    logic [4:0]           ph_addr;
    logic                 two_halves;
    logic [15:0]          laddr;
    logic                 access_en;
    logic [31:0]          wdata;
    logic [31:0]          hrdata;
    logic [7:0]           rst_cnt;
    logic [7:0]           red_cnt;
    logic [7:0]           green_cnt;
    logic [`PIN_W-1:0]    pin_s1;
    logic [`PIN_W-1:0]    pin_s2;
  } bridge_state_s_t;

  typedef struct packed {
    logic [15:0]          scratch;
    logic [31:0]          c_out;
    logic [3:0]           coax;
    logic [5:0]           exp_ctrl;
    logic [2:0][31:0]     exp_out;
    logic [10:0]          dcfg;
    logic [3:0]           ddrive;
    logic [12:0]          spare;
    logic                 red;
    logic                 green;
    logic [15:0]          rdata;
  } user_state_t;
endpackage : local_if_pkg
`default_nettype wire

/* inc/local_if_bus.sv */
`default_nettype none
interface local_if_bus;
  logic             local_reset_n;
  logic             reg_write_strobe;
  logic             reg_read_strobe;
  logic [15:0]      reg_address;
  logic [15:0]      reg_write_data;
  logic [15:0]      reg_read_data;
  logic             user_access_valid;
  logic [31:0]      port_a_in;
  logic [31:0]      port_b_in;
  logic [31:0]      port_c_out;
  logic             coax_level_select;
  logic             coax_direction;
  logic [1:0]       coax_out;
  logic [1:0]       coax_in;
  logic [2:0][31:0] exp_in;
  logic [2:0][31:0] exp_out;
  logic [2:0]       exp_direction;
  logic             exp0_level_select;
  logic             exp1_level_select;
  logic             exp2_level_select;
  logic [2:0]       exp0_board_ident;
  logic [2:0]       exp1_board_ident;
  logic [2:0]       exp2_board_ident;
  logic             delay_cfg_write_enable;
  logic             delay_cfg_line_select;
  logic [7:0]       delay_cfg_read_data;
  logic [7:0]       delay_cfg_write_data;
  logic             delay_cfg_direction;
  logic             delay_line0_output;
  logic             delay_line1_output;
  logic             delay_osc0_output;
  logic             delay_osc1_output;
  logic             delay_line0_input;
  logic             delay_line1_input;
  logic             delay_osc0_gate;
  logic             delay_osc1_gate;
  logic [11:0]      spare_out;
  logic [11:0]      spare_in;
  logic             spare_direction;
  logic             led_red_blink;
  logic             led_green_blink;

  modport bridge (
    output local_reset_n, reg_write_strobe, reg_read_strobe, reg_address,
    output reg_write_data, user_access_valid, port_a_in, port_b_in,
    output coax_in, exp_in, exp0_board_ident, exp1_board_ident,
    output exp2_board_ident, delay_cfg_read_data, delay_line0_output,
    output delay_line1_output, delay_osc0_output, delay_osc1_output,
    output spare_in,
    input  reg_read_data, port_c_out, coax_level_select, coax_direction,
    input  coax_out, exp_out, exp_direction, exp0_level_select,
    input  exp1_level_select, exp2_level_select, delay_cfg_write_enable,
    input  delay_cfg_line_select, delay_cfg_write_data,
    input  delay_cfg_direction, delay_line0_input, delay_line1_input,
    input  delay_osc0_gate, delay_osc1_gate, spare_out, spare_direction,
    input  led_red_blink, led_green_blink
  );
  modport user (
    input  local_reset_n, reg_write_strobe, reg_read_strobe, reg_address,
    input  reg_write_data, user_access_valid, port_a_in, port_b_in,
    input  coax_in, exp_in, exp0_board_ident, exp1_board_ident,
    input  exp2_board_ident, delay_cfg_read_data, delay_line0_output,
    input  delay_line1_output, delay_osc0_output, delay_osc1_output,
    input  spare_in,
    output reg_read_data, port_c_out, coax_level_select, coax_direction,
    output coax_out, exp_out, exp_direction, exp0_level_select,
    output exp1_level_select, exp2_level_select, delay_cfg_write_enable,
    output delay_cfg_line_select, delay_cfg_write_data,
    output delay_cfg_direction, delay_line0_input, delay_line1_input,
    output delay_osc0_gate, delay_osc1_gate, spare_out, spare_direction,
    output led_red_blink, led_green_blink
  );
endinterface : local_if_bus
`default_nettype wire

/* design/local_bridge.sv */
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`default_nettype none
`include "local_if_defines.svh"
module local_bridge (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [`PIN_W-1:0] pins_in,
  output logic [31:0]      pin_port_c,
  output logic [1:0]       pin_coax_out,
  output logic [2:0]       pin_coax_ctrl,
  output logic [2:0][31:0] pin_exp_out,
  output logic [5:0]       pin_exp_ctrl,
  output logic [10:0]      pin_delay_cfg,
  output logic [3:0]       pin_delay_drive,
  output logic [12:0]      pin_spare,
  output logic [1:0]       pin_led,
  local_if_bus.bridge      lb
);
  localparam int RST_CYC_I = (`RST_PULSE_NS + `HCLK_PERIOD_NS - 1)
                             / `HCLK_PERIOD_NS;
  localparam logic [7:0] RST_CYC = 8'(RST_CYC_I);

  local_if_pkg::bridge_state_s_t r;
  local_if_pkg::bridge_state_s_t n;
  logic data_rd;
  logic [`PIN_W-1:0] p;

  // ****************************************************************
  // ahb-lite slave handshake
  // ****************************************************************
  // a read of the forwarding words stalls until the low half, or for RD32 both halves, came back
  assign data_rd   = r.ph_valid && !r.ph_write &&
                     (r.ph_addr == `BR_RD16 || r.ph_addr == `BR_RD32);
  assign hreadyout = (r.st == local_if_pkg::ST_DONE) ||
                     (r.st == local_if_pkg::ST_IDLE && !data_rd);
  assign hresp     = 1'b0;
  assign hrdata    = r.hrdata;

  // ****************************************************************
  // local side drive
  // ****************************************************************
  assign p = r.pin_s2;
  assign lb.local_reset_n     = (r.rst_cnt == 8'h00);
  assign lb.user_access_valid = r.access_en;
  assign lb.reg_write_strobe  = (r.st == local_if_pkg::ST_WR_LO) ||
                                (r.st == local_if_pkg::ST_WR_HI);
  assign lb.reg_read_strobe   = (r.st == local_if_pkg::ST_RD_LO) ||
                                (r.st == local_if_pkg::ST_RD_HI);
  // high half sits one half-word above the low one
  assign lb.reg_address = (r.st == local_if_pkg::ST_SET_HI ||
                           r.st == local_if_pkg::ST_RD_HI ||
                           r.st == local_if_pkg::ST_WR_HI) ?
                          r.laddr + `BR_HALF_STEP : r.laddr;
  assign lb.reg_write_data = (r.st == local_if_pkg::ST_WR_HI) ?
                             r.wdata[31:16] : r.wdata[15:0];
  // synchronised board inputs
  assign lb.port_a_in           = p[194:163];
  assign lb.port_b_in           = p[162:131];
  assign lb.coax_in             = p[130:129];
  assign lb.exp_in              = p[128:33];
  assign lb.exp0_board_ident    = p[32:30];
  assign lb.exp1_board_ident    = p[29:27];
  assign lb.exp2_board_ident    = p[26:24];
  assign lb.delay_cfg_read_data = p[23:16];
  assign lb.delay_line0_output  = p[15];
  assign lb.delay_line1_output  = p[14];
  assign lb.delay_osc0_output   = p[13];
  assign lb.delay_osc1_output   = p[12];
  assign lb.spare_in            = p[11:0];
  // user-driven levels go straight out to the pins
  assign pin_port_c      = lb.port_c_out;
  assign pin_coax_out    = lb.coax_out;
  assign pin_coax_ctrl   = {1'b0, lb.coax_direction, lb.coax_level_select};
  assign pin_exp_out     = lb.exp_out;
  assign pin_exp_ctrl    = {lb.exp2_level_select, lb.exp1_level_select,
                            lb.exp0_level_select, lb.exp_direction};
  assign pin_delay_cfg   = {lb.delay_cfg_direction, lb.delay_cfg_line_select,
                            lb.delay_cfg_write_enable,
                            lb.delay_cfg_write_data};
  assign pin_delay_drive = {lb.delay_osc1_gate, lb.delay_osc0_gate,
                            lb.delay_line1_input, lb.delay_line0_input};
  assign pin_spare       = {lb.spare_direction, lb.spare_out};
  assign pin_led         = {lb.led_green_blink, lb.led_red_blink};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = r;
    n.pin_s1 = pins_in;
    n.pin_s2 = r.pin_s1;
    if (r.rst_cnt != 8'h00) begin
      n.rst_cnt = r.rst_cnt - 8'h01;
    end
    // counters wrap; software takes differences
    if (lb.led_red_blink) begin
      n.red_cnt = r.red_cnt + 8'h01;
    end
    if (lb.led_green_blink) begin
      n.green_cnt = r.green_cnt + 8'h01;
    end
    case (r.st)
      local_if_pkg::ST_IDLE: begin
        if (r.ph_valid && r.ph_write) begin
          if (r.ph_addr == `BR_LADDR) begin
            n.laddr = hwdata[15:0];
          end else if (r.ph_addr == `BR_CTRL) begin
            n.access_en = hwdata[`BR_ACCESS_BIT];
          end else if (r.ph_addr == `BR_WR16 || r.ph_addr == `BR_WR32) begin
            n.wdata      = hwdata;
            n.two_halves = (r.ph_addr == `BR_WR32);
            n.st         = local_if_pkg::ST_WR_LO;
          end else if (r.ph_addr == `BR_RESET) begin
            n.rst_cnt = RST_CYC;
          end
        end else if (data_rd) begin
          n.two_halves = (r.ph_addr == `BR_RD32);
          n.hrdata     = 32'h0000_0000;
          n.st         = local_if_pkg::ST_SET_LO;
        end
      end
      local_if_pkg::ST_SET_LO: n.st = local_if_pkg::ST_RD_LO;
      local_if_pkg::ST_RD_LO: begin
        n.hrdata[15:0] = lb.reg_read_data;
        n.st = r.two_halves ? local_if_pkg::ST_SET_HI : local_if_pkg::ST_DONE;
      end
      local_if_pkg::ST_SET_HI: n.st = local_if_pkg::ST_RD_HI;
      local_if_pkg::ST_RD_HI: begin
        n.hrdata[31:16] = lb.reg_read_data;
        n.st = local_if_pkg::ST_DONE;
      end
      local_if_pkg::ST_WR_LO: begin
        n.st = r.two_halves ? local_if_pkg::ST_WR_HI : local_if_pkg::ST_IDLE;
      end
      local_if_pkg::ST_WR_HI: n.st = local_if_pkg::ST_IDLE;
      default: n.st = local_if_pkg::ST_IDLE;
    endcase
    if (r.st == local_if_pkg::ST_DONE) begin
      n.ph_valid = 1'b0;
    end
    // address phase taken only when the bus is ready
    if (hready && hreadyout) begin
      n.ph_valid = hsel && htrans[1];
      n.ph_write = hwrite;
      n.ph_addr  = haddr[4:0];
      if (hsel && htrans[1] && !hwrite) begin
        if (haddr[4:0] == `BR_LADDR) begin
          n.hrdata = {16'h0000, n.laddr};
        end else if (haddr[4:0] == `BR_CTRL) begin
          n.hrdata = {31'h0, n.access_en};
        end else if (haddr[4:0] == `BR_STATUS) begin
          n.hrdata = {15'h0, (r.rst_cnt != 8'h00), r.green_cnt, r.red_cnt};
        end else begin
          n.hrdata = 32'h0000_0000;
        end
      end
    end
  end

  // single register stage; hclk is timed as the 10 ns (100 MHz) clock of HCLK_PERIOD_NS
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r    <= '0;
      r.st <= local_if_pkg::ST_IDLE;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : local_bridge
`default_nettype wire

/* design/local_user_logic.sv */
`default_nettype none
`include "local_if_defines.svh"
// Contract
// - board reset resets all user registers asynchronously; hresetn here leaves local_reset_n high, so only the module-reset write does
// - bridge pulses reset low on module-reset write
// - one 40 MHz clock times everything; hclk here is timed as 10 ns (100 MHz)
// - write and read strobes last one cycle; a 32-bit write holds the write strobe high two cycles, ST_WR_LO then ST_WR_HI
// - bridge presents register address each access
// - bridge presents 16-bit write datum
// - write datum stable at write-strobe edge
// - strobes honoured only while access qualifier high; only writes are gated, reads are answered whatever the qualifier
// - read value stable at read-strobe edge
// - writable registers reset to defaults; status live
// - every register reachable with 16/32-bit accesses
// - two front-panel inputs as 32-bit buses
// - user drives third front-panel output bus
// - user drives coax select, direction, data
// - coax select 0 TTL, 1 NIM
// - coax direction 0 output, 1 input
// - expansion signals owned as listed per port
// - expansion identifier is 3-bit input
// - delay config write, select, direction, data
// - user drives delay inputs and oscillator gates
// - user drives 12 spare outputs plus direction
// - one-cycle high pulse blinks the LED
module local_user_logic (
  input  wire logic        hclk,
  input  wire logic        ce,
  input  wire logic        led_red_request,
  input  wire logic        led_green_request,
  output logic [15:0]      scratch_view,
  output logic             user_reset_active,
  local_if_bus.user        lb
);
  local_if_pkg::user_state_t r;
  local_if_pkg::user_state_t n;
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic       wr;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // expansion port index 0..2 of an address inside a span, 3 if none
  function automatic logic [1:0] exp_port(input logic [15:0] a,
                                          input logic [15:0] base);
    logic [15:0] off;
    off = a - base;
    if (a < base || off >= `UR_EXP_SPAN || off[0]) begin
      exp_port = 2'd3;
    end else begin
      exp_port = off[3:2];
    end
  endfunction : exp_port

  // half-word select by address bit 1
  function automatic logic [15:0] half(input logic [31:0] w,
                                       input logic [15:0] a);
    half = a[1] ? w[31:16] : w[15:0];
  endfunction : half

  // ****************************************************************
  // reset release
  // ****************************************************************
  // async assert, release after two clean edges so no register sees a
  // reset removal close to the clock edge
  always_ff @(posedge hclk or negedge lb.local_reset_n) begin
    if (!lb.local_reset_n) begin
      rst_sync_r <= 2'b00;
    end else if (ce) begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n             = rst_sync_r[1];
  assign user_reset_active = !rst_n;
  assign scratch_view      = r.scratch;

  // ****************************************************************
  // outputs toward the board
  // ****************************************************************
  assign lb.reg_read_data          = r.rdata;
  assign lb.port_c_out             = r.c_out;
  assign lb.coax_level_select      = r.coax[0];
  assign lb.coax_direction         = r.coax[1];
  assign lb.coax_out               = r.coax[3:2];
  assign lb.exp_direction          = r.exp_ctrl[2:0];
  assign lb.exp0_level_select      = r.exp_ctrl[3];
  assign lb.exp1_level_select      = r.exp_ctrl[4];
  assign lb.exp2_level_select      = r.exp_ctrl[5];
  assign lb.exp_out                = r.exp_out;
  assign lb.delay_cfg_write_data   = r.dcfg[7:0];
  assign lb.delay_cfg_line_select  = r.dcfg[8];
  assign lb.delay_cfg_direction    = r.dcfg[9];
  assign lb.delay_cfg_write_enable = r.dcfg[`DCFG_WE_BIT];
  assign lb.delay_line0_input      = r.ddrive[0];
  assign lb.delay_line1_input      = r.ddrive[1];
  assign lb.delay_osc0_gate        = r.ddrive[2];
  assign lb.delay_osc1_gate        = r.ddrive[3];
  assign lb.spare_out              = r.spare[11:0];
  assign lb.spare_direction        = r.spare[12];
  assign lb.led_red_blink          = r.red;
  assign lb.led_green_blink        = r.green;

  // a strobe with the qualifier low is dropped, not queued
  assign wr = lb.reg_write_strobe && lb.user_access_valid;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [1:0]  wp;
    logic [1:0]  rp;
    logic [15:0] a;
    logic [15:0] d;
    n  = r;
    a  = lb.reg_address;
    d  = lb.reg_write_data;
    wp = exp_port(a, `UR_EXP_OUT);
    rp = exp_port(a, `UR_EXP_IN);
    // pulses last exactly one cycle
    n.dcfg[`DCFG_WE_BIT] = 1'b0;
    n.red   = led_red_request;
    n.green = led_green_request;
    if (wr) begin
      if (a == `UR_SCRATCH) begin
        n.scratch = d;
      end else if (a == `UR_C_LO) begin
        n.c_out[15:0] = d;
      end else if (a == `UR_C_HI) begin
        n.c_out[31:16] = d;
      end else if (a == `UR_COAX) begin
        n.coax = d[3:0];
      end else if (a == `UR_EXP_CTRL) begin
        n.exp_ctrl = d[5:0];
      end else if (a == `UR_DCFG) begin
        n.dcfg = d[10:0];
      end else if (a == `UR_DDRIVE) begin
        n.ddrive = d[3:0];
      end else if (a == `UR_SPARE) begin
        n.spare = d[12:0];
      end else if (a == `UR_LED) begin
        n.red   = d[0] || led_red_request;
        n.green = d[1] || led_green_request;
      end else if (wp != 2'd3) begin
        if (a[1]) begin
          n.exp_out[wp][31:16] = d;
        end else begin
          n.exp_out[wp][15:0] = d;
        end
      end
    end
    // read word follows the address every cycle, so it is settled by
    // the strobe edge as long as the address led by one cycle
    if (a == `UR_SCRATCH) begin
      n.rdata = r.scratch;
    end else if (a == `UR_A_LO || a == `UR_A_HI) begin
      n.rdata = half(lb.port_a_in, a - `UR_A_LO);
    end else if (a == `UR_B_LO || a == `UR_B_HI) begin
      n.rdata = half(lb.port_b_in, a - `UR_B_LO);
    end else if (a == `UR_C_LO || a == `UR_C_HI) begin
      n.rdata = half(r.c_out, a - `UR_C_LO);
    end else if (a == `UR_COAX) begin
      n.rdata = {10'h000, lb.coax_in, r.coax};
    end else if (a == `UR_EXP_CTRL) begin
      n.rdata = {10'h000, r.exp_ctrl};
    end else if (a == `UR_EXP_IDENT) begin
      n.rdata = {7'h00, lb.exp2_board_ident, lb.exp1_board_ident,
                 lb.exp0_board_ident};
    end else if (a == `UR_DCFG) begin
      n.rdata = {6'h00, r.dcfg[9:0]};
    end else if (a == `UR_DSTAT) begin
      n.rdata = {4'h0, lb.delay_osc1_output, lb.delay_osc0_output,
                 lb.delay_line1_output, lb.delay_line0_output,
                 lb.delay_cfg_read_data};
    end else if (a == `UR_DDRIVE) begin
      n.rdata = {12'h000, r.ddrive};
    end else if (a == `UR_SPARE) begin
      n.rdata = {3'h0, r.spare[12], lb.spare_in};
    end else if (wp != 2'd3) begin
      n.rdata = half(r.exp_out[wp], {14'h0000, a[1], 1'b0});
    end else if (rp != 2'd3) begin
      n.rdata = half(lb.exp_in[rp], {14'h0000, a[1], 1'b0});
    end else begin
      n.rdata = 16'h0000;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      r         <= '0;
      r.scratch <= `SCRATCH_RST;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : local_user_logic
`default_nettype wire

/* dv/local_if_assertions.sv */
`default_nettype none
`include "local_if_defines.svh"
// ******************************************************************
// local link checker
// ******************************************************************
module local_if_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        local_reset_n,
  input wire logic        reg_write_strobe,
  input wire logic        reg_read_strobe,
  input wire logic [15:0] reg_address,
  input wire logic [15:0] reg_write_data,
  input wire logic [15:0] reg_read_data,
  input wire logic        user_access_valid,
  input wire logic [31:0] port_c_out,
  input wire logic        coax_level_select,
  input wire logic        coax_direction,
  input wire logic        delay_cfg_write_enable,
  input wire logic        led_red_blink
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // only a wide write may give two strobes in a row, low half first
  a_wr_pair: assert property (reg_write_strobe ##1
    reg_write_strobe |-> reg_address == $past(reg_address) + 16'h0002
    ##1 !reg_write_strobe) else $error("write strobe pair malformed");
  a_rd_addr: assert property (reg_read_strobe |-> $stable(reg_address))
    else $error("address moved at read strobe");
  a_undec_zero: assert property (reg_read_strobe &&
    reg_address == 16'h0010 |-> reg_read_data == 16'h0000)
    else $error("undecoded read not zero");
  // pulse lasts exactly the ten cycles of the bridge's counter
  a_rst_len: assert property ($fell(local_reset_n) |->
    !local_reset_n [*8] ##1 !local_reset_n [*2] ##1 local_reset_n)
    else $error("bad reset pulse");
  a_c_write: assert property (reg_write_strobe &&
    user_access_valid && reg_address == `UR_C_LO |=> port_c_out[15:0] ==
    $past(reg_write_data)) else $error("port c write lost");
  a_c_refused: assert property (reg_write_strobe &&
    !user_access_valid && reg_address == `UR_C_LO |=> $stable(port_c_out))
    else $error("write taken without access");
  a_coax_map: assert property (reg_write_strobe &&
    user_access_valid && reg_address == `UR_COAX |=>
    {coax_direction, coax_level_select} == $past(reg_write_data[1:0]))
    else $error("coax controls wrong");
  a_dcfg_pulse: assert property (delay_cfg_write_enable
    |=> !delay_cfg_write_enable) else $error("delay write enable long");
  a_led_pulse: assert property (led_red_blink |=> !led_red_blink)
    else $error("red blink long");
  a_rst_zero: assert property (!local_reset_n ##1 !local_reset_n
    |-> port_c_out == 32'h0000_0000) else $error("port c not reset");
  cover property (reg_write_strobe && user_access_valid);
  cover property (reg_read_strobe);
  cover property ($rose(local_reset_n));
endmodule : local_if_assertions
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
`include "local_if_defines.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h seen %h", n, e, s); end end
// ******************************************************************
// bench
// ******************************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, rr, act;
  logic [1:0]   htrans;
  logic [31:0]  haddr, hwdata, hrdata, x, q, pc;
  logic [194:0] pins;
  logic [15:0]  sv;
  int           num_errors, compares, n;
  local_if_bus lb();
  local_bridge i_local_bridge (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .pins_in(pins), .pin_port_c(pc), .pin_coax_out(),
    .pin_coax_ctrl(), .pin_exp_out(), .pin_exp_ctrl(), .pin_delay_cfg(),
    .pin_delay_drive(), .pin_spare(), .pin_led(), .lb(lb));
  local_user_logic i_local_user_logic (.hclk, .ce(1'b1),
    .led_red_request(rr), .led_green_request(rr), .scratch_view(sv),
    .user_reset_active(act), .lb(lb));
  local_if_assertions i_local_if_assertions (.hclk, .hresetn,
    .local_reset_n(lb.local_reset_n), .reg_write_strobe(lb.reg_write_strobe),
    .reg_read_strobe(lb.reg_read_strobe), .reg_address(lb.reg_address),
    .reg_write_data(lb.reg_write_data), .reg_read_data(lb.reg_read_data),
    .user_access_valid(lb.user_access_valid), .port_c_out(lb.port_c_out),
    .coax_level_select(lb.coax_level_select),
    .coax_direction(lb.coax_direction), .led_red_blink(lb.led_red_blink),
    .delay_cfg_write_enable(lb.delay_cfg_write_enable));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] ident_exp(input logic [194:0] p);
    return {7'h00, p[26:24], p[29:27], p[32:30]};
  endfunction : ident_exp
  task automatic final_report();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // hready sampled at negedge, where the combinational answer has settled
  task automatic hold(output logic [31:0] r);
    logic k;
    int   c;
    c = 0;
    do begin
      @(negedge hclk);
      k = hreadyout;
      r = hrdata;
      @(posedge hclk);
      c++;
      if (c > 300) begin num_errors++; final_report(); end
    end while (k !== 1'b1);
  endtask : hold
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {27'h0, a}; hwrite <= w;
    hold(r);
    htrans <= 2'h0; hwdata <= d;
    hold(r);
  endtask : bus
  task automatic lw(input logic [15:0] a, input logic [31:0] d, input logic w);
    bus(1'b1, `BR_LADDR, {16'h0, a}, q);
    bus(1'b1, w ? `BR_WR32 : `BR_WR16, d, q);
  endtask : lw
  task automatic lr(input logic [15:0] a, input logic w);
    bus(1'b1, `BR_LADDR, {16'h0, a}, q);
    bus(1'b0, w ? `BR_RD32 : `BR_RD16, 32'h0, q);
  endtask : lr
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // main sequence; user end has no reset until the bridge pulses it
  initial begin
    {hresetn, hsel, htrans, haddr, hwrite, hwdata, rr, pins} = '0;
    {num_errors, compares, x} = {32'h0, 32'h0, 32'h016D};
    repeat (16) @(posedge hclk);
    x = lfsr(x);
    hresetn <= 1'b1;
    pins <= {x[2:0], {6{x}}};
    @(posedge hclk);
    bus(1'b1, `BR_RESET, 32'h0, q);
    for (n = 0; n < 400 && (act !== 1'b0 || n < 20); n++) @(posedge hclk);
    `CHK("reset wait", 1'b1, n < 400)
    `CHK("scratch", `SCRATCH_RST, sv)
    bus(1'b1, `BR_CTRL, 32'h1, q);
    lr(`UR_SCRATCH, 1'b0); `CHK("scratch rd", `SCRATCH_RST, q[15:0])
    lr(`UR_EXP_IDENT, 1'b0); `CHK("ident", ident_exp(pins), q[15:0])
    lr(`UR_A_LO, 1'b1); `CHK("port a", pins[194:163], q)
    lr(16'h0010, 1'b0); `CHK("undecoded", 16'h0000, q[15:0])
    for (int i = 0; i < 8; i++) begin
      x = (i == 0) ? 32'hFFFF_0000 : lfsr(x);
      lw(`UR_COAX, x, 1'b0);
      lw(`UR_DCFG, x, 1'b0);
      lw(`UR_SCRATCH, x, 1'b0);
      lw(`UR_C_LO, x, 1'b1);
      lr(`UR_C_LO, 1'b1);
      `CHK("port c", x, pc)
      `CHK("c rd", x, q)
      `CHK("scratch wr", x[15:0], sv)
    end
    bus(1'b1, `BR_CTRL, 32'h0, q);
    lw(`UR_C_LO, ~x, 1'b1);
    bus(1'b1, `BR_CTRL, 32'h1, q);
    lr(`UR_C_LO, 1'b1); `CHK("refused", x, q)
    rr <= 1'b1;
    @(posedge hclk);
    rr <= 1'b0;
    lw(`UR_LED, 32'h2, 1'b0);
    lr(`UR_SPARE, 1'b0); `CHK("spare", {4'h0, pins[11:0]}, q[15:0])
    bus(1'b0, `BR_STATUS, 32'h0, q); `CHK("blinks", 32'h0000_0201, q)
    final_report();
  end
endmodule : tb_top
`default_nettype wire
